// >>> exec_map.svh
// register offsets, field positions, opcodes and reset values of the exec unit
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
// apb byte offsets
`define OFS_CTRL 8'h00
`define OFS_INSTR 8'h04
`define OFS_SRC 8'h08
`define OFS_SRC2 8'h0C
`define OFS_DST 8'h10
`define OFS_DST2 8'h14
`define OFS_R0 8'h18
`define OFS_BASE 8'h1C
`define OFS_STAT 8'h20
`define OFS_WP 8'h24
`define OFS_PC 8'h28
`define OFS_RES0 8'h2C
`define OFS_RES1 8'h30
`define OFS_RES2 8'h34
`define OFS_STATE 8'h38
// status word bits, flag n sits at bit 15-n
`define ST_LGT 15
`define ST_AGT 14
`define ST_EQ 13
`define ST_C 12
`define ST_OV 11
`define ST_PAR 10
// opcodes
`define OP_ONES_CMP 6'h08
`define OP_BITS_OUT 6'h0C
`define OP_BITS_IN 6'h0D
`define OP_MUL 6'h0E
`define OP_DIV 6'h0F
`define OP_ASR 8'h08
`define OP_LSR 8'h09
`define OP_ASL 8'h0A
`define OP_ROR 8'h0B
`define OP_CTX_CALL 10'h010
`define OP_X 10'h012
`define OP_BYTE_SWAP 10'h01B
`define OP_MAGNITUDE 10'h01D
// counts
`define FULL_CNT 5'h10
`define BYTE_MAX 5'h08
`define RST_W16 16'h0000
`endif

// >>> exec_pkg.sv
// types of the exec unit
package exec_pkg;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_SER} fsm_t;
  typedef struct packed {
    fsm_t fsm;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] instr, act, src, src2, dst, dst2, r0, base, st, wp, pc;
    logic [15:0] res0, res1, res2, sh, acc;
    logic [1:0] ext;
    logic [4:0] cnt, idx;
    logic phase, is_in, byte_mode;
    logic [1:0] ptr_inc;
    logic inhibit, irq_take, err, done;
    logic [10:0] io_addr;
    logic io_out, io_wr, io_rd, fetch;
  } state_t;
endpackage : exec_pkg

// >>> exec_unit.sv
// exec unit for multiply/divide, compare, serial i/o, shifts, single operand
`timescale 1ns/1ns
`include "exec_map.svh"
module exec_unit
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bit serial i/o space
  output logic [10:0] io_addr,
  output logic io_data_out,
  output logic io_wr_strobe,
  output logic io_rd_strobe,
  input wire logic io_data_in,
  // core handshake
  input wire logic irq_line,
  output logic irq_take,
  output logic fetch_cycle_flag
);
  exec_pkg::state_t q, d;
  logic [5:0] op6;
  logic [7:0] op8;
  logic [9:0] op10;
  logic [3:0] cf;

  // ------------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------------
  // flags 0-2 against zero; byte results are judged as signed bytes
  function automatic logic [15:0] cmp0(input logic [15:0] st,
                                       input logic [15:0] v,
                                       input logic bm);
    logic [15:0] w;
    w = bm ? {v[7:0], 8'h00} : v;
    cmp0 = st;
    cmp0[`ST_LGT] = (w != `RST_W16);
    cmp0[`ST_AGT] = (w != `RST_W16) && !w[15];
    cmp0[`ST_EQ] = (w == `RST_W16);
  endfunction : cmp0

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_STATE);
  endfunction : mapped

  // returns {overflow, carry, result}
  function automatic logic [17:0] shift(input logic [1:0] k,
                                        input logic [15:0] v,
                                        input logic [4:0] n);
    logic [15:0] r;
    logic c;
    logic ov;
    r = v;
    c = 1'b0;
    ov = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (5'(i) < n)
      begin
        case (k)
          2'h2:
          begin
            c = r[15];
            r = {r[14:0], 1'b0};
            ov = ov | r[15];
          end
          2'h0:
          begin
            c = r[0];
            r = {r[15], r[15:1]};
          end
          2'h3:
          begin
            c = r[0];
            r = {r[0], r[15:1]};
          end
          default:
          begin
            c = r[0];
            r = {1'b0, r[15:1]};
          end
        endcase
      end
    end
    shift = {ov, c, r};
  endfunction : shift

  function automatic logic [15:0] rd(input exec_pkg::state_t s,
                                     input logic [7:0] a);
    case (a)
      `OFS_CTRL: rd = {14'h0000, s.ext};
      `OFS_INSTR: rd = s.instr;
      `OFS_SRC: rd = s.src;
      `OFS_SRC2: rd = s.src2;
      `OFS_DST: rd = s.dst;
      `OFS_DST2: rd = s.dst2;
      `OFS_R0: rd = s.r0;
      `OFS_BASE: rd = s.base;
      `OFS_STAT: rd = s.st;
      `OFS_WP: rd = s.wp;
      `OFS_PC: rd = s.pc;
      `OFS_RES0: rd = s.res0;
      `OFS_RES1: rd = s.res1;
      `OFS_RES2: rd = s.res2;
      `OFS_STATE: rd = {8'h00, s.ptr_inc, s.byte_mode, s.err, s.done,
                        s.inhibit, s.fsm};
      default: rd = `RST_W16;
    endcase
  endfunction : rd

  assign op6 = q.act[15:10];
  assign op8 = q.act[15:8];
  assign op10 = q.act[15:6];
  assign cf = (op6 == `OP_BITS_OUT || op6 == `OP_BITS_IN) ? q.act[9:6] :
              q.act[7:4];

  // ------------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] num;
    logic [17:0] sr;
    logic [4:0] n;
    logic last;
    logic [15:0] v;
    num = {q.dst, q.dst2};
    sr = 18'h00000;
    n = 5'h00;
    last = 1'b0;
    v = `RST_W16;
    d = q;
    d.io_wr = 1'b0;
    d.io_rd = 1'b0;
    d.fetch = 1'b0;
    d.irq_take = 1'b0;
    // apb: one wait state, write lands on the pready edge
    if (psel && penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.prdata = {16'h0000, rd(q, paddr)};
      d.pslverr = !mapped(paddr);
    end
    else if (q.pready)
    begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      // operand writes while busy would corrupt the run, so they are dropped
      if (psel && pwrite && mapped(paddr) && q.fsm == exec_pkg::S_IDLE)
      begin
        case (paddr)
          `OFS_CTRL:
          begin
            d.ext = pwdata[2:1];
            if (pwdata[0])
            begin
              d.act = q.instr;
              d.fetch = 1'b1;
              d.done = 1'b0;
              d.err = 1'b0;
              d.fsm = exec_pkg::S_EXEC;
            end
          end
          `OFS_INSTR: d.instr = pwdata[15:0];
          `OFS_SRC: d.src = pwdata[15:0];
          `OFS_SRC2: d.src2 = pwdata[15:0];
          `OFS_DST: d.dst = pwdata[15:0];
          `OFS_DST2: d.dst2 = pwdata[15:0];
          `OFS_R0: d.r0 = pwdata[15:0];
          `OFS_BASE: d.base = pwdata[15:0];
          `OFS_STAT: d.st = pwdata[15:0];
          `OFS_WP: d.wp = pwdata[15:0];
          `OFS_PC: d.pc = pwdata[15:0];
          default: d.ext = q.ext;
        endcase
      end
    end

    case (q.fsm)
      exec_pkg::S_IDLE: d.idx = 5'h00;
      exec_pkg::S_EXEC:
      begin
        last = 1'b1;
        if (op6 == `OP_MUL)
          {d.res0, d.res1} = 32'(q.src) * 32'(q.dst);
        else if (op6 == `OP_DIV)
        begin
          if (q.src <= q.dst)
          begin
            d.st[`ST_OV] = 1'b1;
            d.res0 = q.dst;
            d.res1 = q.dst2;
          end
          else
          begin
            d.st[`ST_OV] = 1'b0;
            d.res0 = 16'(num / 32'(q.src));
            d.res1 = 16'(num % 32'(q.src));
          end
        end
        else if (op6 == `OP_ONES_CMP)
          d.st[`ST_EQ] = ((q.dst & q.src) == q.src);
        else if (op6 == `OP_BITS_OUT || op6 == `OP_BITS_IN)
        begin
          last = 1'b0;
          n = (cf == 4'h0) ? `FULL_CNT : {1'b0, cf};
          d.cnt = n;
          d.byte_mode = (n <= `BYTE_MAX);
          d.ptr_inc = (n <= `BYTE_MAX) ? 2'h1 : 2'h2;
          d.is_in = (op6 == `OP_BITS_IN);
          d.sh = q.src;
          d.acc = `RST_W16;
          d.idx = 5'h00;
          d.phase = 1'b0;
          d.fsm = exec_pkg::S_SER;
        end
        else if (op8 >= `OP_ASR && op8 <= `OP_ROR)
        begin
          n = (cf != 4'h0) ? {1'b0, cf} :
              ((q.r0[3:0] == 4'h0) ? `FULL_CNT : {1'b0, q.r0[3:0]});
          sr = shift(op8[1:0], q.dst, n);
          d.res0 = sr[15:0];
          d.st = cmp0(q.st, sr[15:0], 1'b0);
          d.st[`ST_C] = sr[16];
          if (op8 == `OP_ASL)
            d.st[`ST_OV] = sr[17];
        end
        else if (op10 == `OP_CTX_CALL)
        begin
          d.wp = q.src;
          d.pc = q.src2;
          d.res0 = q.wp;
          d.res1 = q.pc;
          d.res2 = q.st;
        end
        else if (op10 == `OP_MAGNITUDE)
        begin
          d.st = cmp0(q.st, q.src, 1'b0);
          d.st[`ST_C] = 1'b0;
          d.st[`ST_OV] = (q.src == 16'h8000);
          d.res0 = q.src[15] ? 16'(-q.src) : q.src;
        end
        else if (op10 == `OP_BYTE_SWAP)
          d.res0 = {q.src[7:0], q.src[15:8]};
        else if (op10 == `OP_X)
        begin
          // target word sits in src; no acquisition flag for it
          last = 1'b0;
          d.act = q.src;
          d.pc = q.pc + {13'h0000, q.ext, 1'b0};
          d.fetch = 1'b0;
        end
        else
          d.err = 1'b1;
      end
      exec_pkg::S_SER:
      begin
        // phase 0 drives address and strobe, phase 1 samples the input
        d.phase = !q.phase;
        if (!q.phase)
        begin
          d.io_addr = q.base[11:1] + 11'(q.idx);
          d.io_out = q.sh[0];
          d.io_wr = !q.is_in;
          d.io_rd = q.is_in;
        end
        else
        begin
          d.sh = {1'b0, q.sh[15:1]};
          if (q.is_in)
            d.acc[q.idx[3:0]] = io_data_in;
          d.idx = q.idx + 5'h01;
          if (q.idx + 5'h01 == q.cnt)
          begin
            last = 1'b1;
            v = q.is_in ? d.acc : q.src;
            if (q.byte_mode)
              v = {8'h00, v[7:0]};
            d.res0 = v;
            d.st = cmp0(q.st, v, q.byte_mode);
            if (q.byte_mode)
              d.st[`ST_PAR] = ^v[7:0];
          end
        end
      end
      default: d.fsm = exec_pkg::S_IDLE;
    endcase

    // instruction boundary: interrupt sampling
    if (last)
    begin
      d.fsm = exec_pkg::S_IDLE;
      d.done = 1'b1;
      if (q.fsm == exec_pkg::S_EXEC && op10 == `OP_CTX_CALL)
        d.inhibit = 1'b1;
      else
      begin
        // the call skipped its own sample; the next end samples again
        d.irq_take = irq_line;
        d.inhibit = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign io_addr = q.io_addr;
  assign io_data_out = q.io_out;
  assign io_wr_strobe = q.io_wr;
  assign io_rd_strobe = q.io_rd;
  assign irq_take = q.irq_take;
  assign fetch_cycle_flag = q.fetch;

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ex;
  assign ex = (q.fsm == exec_pkg::S_EXEC);

  sequence s_access;
    psel && penable && !q.pready;
  endsequence
  property p_apb;
    s_access |=> q.pready ##1 !q.pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing");

  property p_mul;
    ex && op6 == `OP_MUL |=>
      {q.res0, q.res1} == 32'($past(q.src)) * 32'($past(q.dst));
  endproperty
  a_mul: assert property (p_mul) else $error("bad product");

  property p_div_ovf;
    ex && op6 == `OP_DIV && q.src <= q.dst |=>
      q.st[`ST_OV] && q.res0 == $past(q.dst) && q.res1 == $past(q.dst2);
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("div ovf");

  property p_ones_cmp;
    ex && op6 == `OP_ONES_CMP |=>
      q.st[`ST_EQ] == (($past(q.dst) & $past(q.src)) == $past(q.src));
  endproperty
  a_ones_cmp: assert property (p_ones_cmp)
    else $error("ones match flag");

  property p_cnt;
    ex && (op6 == `OP_BITS_OUT || op6 == `OP_BITS_IN) |=>
      q.cnt != 5'h00 && q.ptr_inc == (q.cnt <= `BYTE_MAX ? 2'h1 : 2'h2);
  endproperty
  a_cnt: assert property (p_cnt) else $error("serial count");

  property p_byte_swap;
    ex && op10 == `OP_BYTE_SWAP |=> q.st == $past(q.st)
      && q.res0 == {$past(q.src[7:0]), $past(q.src[15:8])};
  endproperty
  a_byte_swap: assert property (p_byte_swap) else $error("swap");

  property p_ctx_call;
    ex && op10 == `OP_CTX_CALL |=> q.inhibit && !q.irq_take
      && q.res0 == $past(q.wp) && q.wp == $past(q.src);
  endproperty
  a_ctx_call: assert property (p_ctx_call)
    else $error("context call");

  property p_x;
    ex && op10 == `OP_X |=> !q.fetch && ex;
  endproperty
  a_x: assert property (p_x) else $error("execute fetch");
endmodule : exec_unit

// >>> bit_io_model.sv
// behavioural bit-serial i/o space facing the exec unit
`timescale 1ns/1ns
module bit_io_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial i/o
  input wire logic [10:0] io_addr,
  input wire logic io_data_out,
  input wire logic io_wr_strobe,
  input wire logic io_rd_strobe,
  output logic io_data_in
);
  logic mem [0:2047];
  logic tog_q;
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = i[1];
  end
  always @(posedge pclk)
  begin
    if (io_wr_strobe)
      mem[io_addr] <= io_data_out;
  end
  // answers while the read strobe stands; toggles elsewhere so a
  // mistimed sample cannot pass on a stale copy
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog_q <= 1'b0;
    else
      tog_q <= ~tog_q;
  end
  assign io_data_in = io_rd_strobe ? mem[io_addr] : tog_q;
endmodule : bit_io_model

// >>> cpu_exec_formats_three_to_six_bench.sv
// self-checking bench of the exec unit against a bit-serial i/o model
`timescale 1ns/1ns
`include "exec_map.svh"
module cpu_exec_formats_three_to_six_bench;
  typedef struct {string nm; logic [32:0] v; logic [32:0] m;} exp_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, t;
  logic [10:0] io_addr, ad;
  logic io_data_out, io_wr_strobe, io_rd_strobe, io_data_in;
  logic irq_line, irq_take, fetch_cycle_flag;
  logic [15:0] a, b, c, s, m;
  logic [17:0] sr;
  logic [3:0] ctab [5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'h3};
  exp_t expq[$];
  exp_t e;
  int fail_count = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  int fetch_cnt = 0;
  int cnt, f0;

  exec_unit exec_unit_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .io_addr, .io_data_out,
    .io_wr_strobe, .io_rd_strobe, .io_data_in, .irq_line, .irq_take,
    .fetch_cycle_flag);
  bit_io_model bit_io_model_inst (.pclk, .presetn, .io_addr, .io_data_out,
    .io_wr_strobe, .io_rd_strobe, .io_data_in);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic summarize();
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [32:0] x,
    input logic [32:0] g);
    n_tests++;
    if (g !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
      fail_count++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] ad,
    input logic [15:0] d, output logic [31:0] rq);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    logic [31:0] r;
    apb(1'b1, ad, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input string nm,
    input logic [15:0] ev, input logic [15:0] mv = 16'hFFFF);
    logic [31:0] r;
    expq.push_back('{nm, {17'h00000, ev}, {17'h1FFFF, mv}});
    apb(1'b0, ad, 16'h0000, r);
  endtask : rd

  // polls the state word until the unit is idle again
  task automatic run(input logic [15:0] ins, input logic [1:0] ext = 2'b00);
    logic [31:0] r;
    wr(`OFS_INSTR, ins);
    wr(`OFS_CTRL, {13'h0000, ext, 1'b1});
    do
    begin
      expq.push_back('{"state", 33'h000000000, 33'h000000000});
      apb(1'b0, `OFS_STATE, 16'h0000, r);
    end
    while (r[1:0] !== 2'b00);
  endtask : run

  function automatic logic [15:0] rnd();
    logic [31:0] r;
    r = $urandom;
    return r[15:0];
  endfunction : rnd

  function automatic logic [17:0] shf(input logic [7:0] op,
    input logic [15:0] v, input int n);
    logic cy, ov;
    cy = 1'b0;
    ov = 1'b0;
    repeat (n)
    begin
      cy = (op == `OP_ASL) ? v[15] : v[0];
      ov = ov | (op == `OP_ASL && v[14]);
      case (op)
        `OP_ASL: v = {v[14:0], 1'b0};
        `OP_ASR: v = {v[15], v[15:1]};
        `OP_LSR: v = {1'b0, v[15:1]};
        default: v = {v[0], v[15:1]};
      endcase
    end
    return {cy, ov, v};
  endfunction : shf

  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
      pwrite === 1'b0 && expq.size() > 0)
    begin
      e = expq.pop_front();
      if (e.m !== 33'h000000000)
        chk(e.nm, e.v & e.m, {pslverr, prdata} & e.m);
    end
    if (irq_take === 1'b1)
      irq_cnt++;
    if (fetch_cycle_flag === 1'b1)
      fetch_cnt++;
  end

  initial
  begin
    #(50 * 30000);
    fail_count++;
    summarize();
  end

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    irq_line = 1'b0;
    void'($urandom(27741));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_RES0, "res0_rst", 16'h0000);
    rd(`OFS_STAT, "stat_rst", 16'h0000);
    expq.push_back('{"unmapped", 33'h100000000, 33'h1FFFFFFFF});
    apb(1'b0, 8'h3C, 16'h0000, t);
    a = 16'hFFFF;
    b = rnd();
    wr(`OFS_SRC, a);
    wr(`OFS_DST, b);
    run({`OP_MUL, 10'h000});
    q = a * b;
    rd(`OFS_RES0, "mul_hi", q[31:16]);
    rd(`OFS_RES1, "mul_lo", q[15:0]);
    for (int j = 0; j < 2; j++)
    begin
      a = rnd() | 16'h8000;
      b = rnd() & 16'h7FFF;
      c = rnd();
      if (j == 1)
        a = b;
      q = {b, c} / a;
      t = {b, c} % a;
      wr(`OFS_STAT, 16'h0000);
      wr(`OFS_SRC, a);
      wr(`OFS_DST, b);
      wr(`OFS_DST2, c);
      run({`OP_DIV, 10'h000});
      rd(`OFS_RES0, "quot", j ? b : q[15:0]);
      rd(`OFS_RES1, "rem", j ? c : t[15:0]);
      rd(`OFS_STAT, "div_ov", j ? 16'h0800 : 16'h0000, 16'h0800);
      a = rnd() | 16'h0001;
      b = j ? (a & 16'hFFFE) : (a | rnd());
      wr(`OFS_STAT, 16'h0000);
      wr(`OFS_SRC, a);
      wr(`OFS_DST, b);
      run({`OP_ONES_CMP, 10'h000});
      rd(`OFS_STAT, "match", j ? 16'h0000 : 16'h2000);
      a = j ? rnd() : 16'h8000;
      wr(`OFS_STAT, 16'h0000);
      wr(`OFS_SRC, a);
      run({`OP_MAGNITUDE, 6'h00});
      rd(`OFS_RES0, "mag", a[15] ? -a : a);
      rd(`OFS_STAT, "mag_st", {a != 0, $signed(a) > 0, a == 16'h0000, 1'b0,
        a == 16'h8000, 11'h000});
    end
    for (logic [7:0] o = `OP_ASR; o <= `OP_ROR; o++)
      for (int j = 0; j < 3; j++)
      begin
        a = rnd();
        b = rnd();
        cnt = (j == 0) ? int'(a[3:0] | 4'h1) :
          (j == 1) ? int'(a[7:4] | 4'h1) : 16;
        sr = shf(o, b, cnt);
        wr(`OFS_STAT, 16'h0000);
        wr(`OFS_DST, b);
        wr(`OFS_R0, {a[15:8], 4'h0, (j == 1) ? cnt[3:0] : 4'h0});
        run({o, (j == 0) ? cnt[3:0] : 4'h0, 4'h0});
        rd(`OFS_RES0, "shift", sr[15:0]);
        rd(`OFS_STAT, "shift_st", {sr[15:0] != 0, $signed(sr[15:0]) > 0,
          sr[15:0] == 16'h0000, sr[17:16], 11'h000});
      end
    for (int i = 0; i < 5; i++)
    begin
      a = rnd();
      b = rnd();
      cnt = (ctab[i] == 4'h0) ? 16 : int'(ctab[i]);
      m = 16'hFFFF >> (16 - cnt);
      ad = a[10:0] & 11'h3FF;
      wr(`OFS_STAT, 16'h0000);
      wr(`OFS_BASE, {4'h0, ad, 1'b0});
      wr(`OFS_SRC, b);
      run({`OP_BITS_OUT, ctab[i], 6'h00});
      for (int k = 0; k < cnt; k++)
        chk("io_bit", {32'h00000000, b[k]},
          {32'h00000000, bit_io_model_inst.mem[ad + 11'(k)]});
      rd(`OFS_STATE, "ser_mode", {8'h00, (cnt <= 8) ? 3'b011 : 3'b100,
        5'h00}, 16'h00E0);
      rd(`OFS_BASE, "base", {4'h0, ad, 1'b0}, 16'h0FFE);
      wr(`OFS_SRC, a);
      run({`OP_BITS_IN, ctab[i], 6'h00});
      s = b & m;
      rd(`OFS_RES0, "ser_in", s);
      rd(`OFS_STAT, "ser_st", {2'b00, s == 16'h0000, 2'b00,
        cnt <= 8 && ^s[7:0], 10'h000}, 16'h2400);
    end
    a = rnd() & 16'hFFFE;
    b = rnd() & 16'hFFFE;
    c = rnd() & 16'hFFFE;
    m = rnd() & 16'hFFFE;
    s = rnd() & 16'hFC00;
    wr(`OFS_WP, a);
    wr(`OFS_PC, b);
    wr(`OFS_STAT, s);
    wr(`OFS_SRC, c);
    wr(`OFS_SRC2, m);
    irq_line <= 1'b1;
    run({`OP_CTX_CALL, 6'h00});
    rd(`OFS_WP, "wp", c);
    rd(`OFS_PC, "pc", m);
    rd(`OFS_RES0, "old_wp", a);
    rd(`OFS_RES1, "old_pc", b);
    rd(`OFS_RES2, "old_st", s);
    chk("irq_call", 33'h000000000, 33'(irq_cnt));
    a = rnd();
    wr(`OFS_SRC, a);
    run({`OP_BYTE_SWAP, 6'h00});
    chk("irq_next", 33'h000000001, 33'(irq_cnt));
    irq_line <= 1'b0;
    rd(`OFS_RES0, "swap", {a[7:0], a[15:8]});
    rd(`OFS_STAT, "swap_st", s);
    a = rnd() & 16'hFFFE;
    wr(`OFS_PC, a);
    wr(`OFS_SRC, {`OP_BYTE_SWAP, 6'h00});
    f0 = fetch_cnt;
    run({`OP_X, 6'h00}, 2'b10);
    chk("fetch", 33'(f0 + 1), 33'(fetch_cnt));
    rd(`OFS_PC, "x_pc", a + 16'h0004);
    summarize();
  end
endmodule : cpu_exec_formats_three_to_six_bench
